// ### verilog/vcp_regs.vh
// Function
// - Accept 16-bit linear samples at 8 kHz
// - Transmit high-pass removes content below 65 Hz
// - Order: high-pass, equalizer, gain, compression
// - Per-direction gain, mute up to plus 6 dB
// - 0000h mutes, 4000h unity, 7FFFh maximum
// - Gain factor is coefficient over 16384
// - Post-gain samples feed DTMF when enabled
// - Compress to 8-bit A-law or mu-law
// - 8-bit word one slot, 16-bit two
// - Receive expands 8-bit words to 16 bits
// - Bypass bit joins two bytes instead
// - Deliver 16-bit samples to D/A converter
// - Mute bits silence paths, coefficients kept
// - Four-tap equalizer per direction, own coefficients
// - Largest code reached, larger inputs clip
`ifndef VCP_REGS_VH
`define VCP_REGS_VH

`define VCP_COEF_SHIFT 14
`define VCP_HPF_SHIFT 4
`define VCP_HPF_STAGES 2
`define VCP_EQ_TAPS 4
`define VCP_FIFO_DEPTH 8
`define VCP_FIFO_AW 3
`define VCP_MU_CLIP 14'h1FDF
`define VCP_MU_BIAS 14'h0021
`define VCP_MU_POS 8'hFF
`define VCP_MU_NEG 8'h7F
`define VCP_A_POS 8'hD5
`define VCP_A_NEG 8'h55
`define VCP_DEC_BIAS 16'h0084
`define VCP_A_SEG1 16'h0108
`define VCP_SAT_MAX 16'h7FFF
`define VCP_SAT_MIN 16'h8000

`endif

// ### verilog/vcp_fifo.v
`default_nettype none
module vcp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             nrst,
  // Filling side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // Draining side
  output reg  [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  // Output register refills when empty or being taken
  assign pop      = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  always @(posedge clk) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always @(posedge clk) begin
    if (!nrst) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_data  <= {WIDTH{1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop) begin
        rd_ptr   <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        out_data <= mem[rd_ptr];
      end
      if (push && !pop)
        count <= count + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        count <= count - {{AW{1'b0}}, 1'b1};
      if (pop)
        out_valid <= 1'b1;
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

endmodule // vcp_fifo
`default_nettype wire

// ### verilog/vcp_top.v
`include "vcp_regs.vh"
`default_nettype none
module vcp_top (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Converter side
  input  wire [15:0] adc_sample,
  input  wire        adc_valid,
  output reg         adc_ready,
  output reg  [15:0] dac_sample,
  output reg         dac_valid,
  // Highway side
  output wire [7:0]  tx_slot_data,
  output wire        tx_slot_valid,
  input  wire        tx_slot_ready,
  input  wire [7:0]  rx_slot_data,
  input  wire        rx_slot_valid,
  // DTMF decoder tap
  input  wire        dtmf_enable,
  output reg  [15:0] dtmf_sample,
  output reg         dtmf_valid,
  // Control
  input  wire [15:0] tx_gain_coeff,
  input  wire [15:0] rx_gain_coeff,
  input  wire [63:0] tx_eq_coeffs,
  input  wire [63:0] rx_eq_coeffs,
  input  wire        tx_digital_mute,
  input  wire        rx_digital_mute,
  input  wire        compand_en,
  input  wire        law_alaw,
  input  wire        expansion_bypass_bit
);

  localparam [2:0] TX_IDLE = 3'h0;
  localparam [2:0] TX_HPF  = 3'h1;
  localparam [2:0] TX_EQ   = 3'h2;
  localparam [2:0] TX_GAIN = 3'h3;
  localparam [2:0] TX_PUSH = 3'h4;
  localparam [1:0] RX_IDLE = 2'h0;
  localparam [1:0] RX_EQ   = 2'h1;
  localparam [1:0] RX_GAIN = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  function [15:0] sat16;
    input signed [35:0] v;
    begin
      if (v > 36'sh0_0000_7FFF)
        sat16 = `VCP_SAT_MAX;
      else if (v < -36'sh0_0000_8000)
        sat16 = `VCP_SAT_MIN;
      else
        sat16 = v[15:0];
    end
  endfunction

  function [15:0] gain;
    input [15:0] x;
    input [15:0] c;
    reg signed [35:0] p;
    begin
      p    = $signed(x) * $signed({2'b00, c[14:0]});
      gain = sat16(p >>> `VCP_COEF_SHIFT);
    end
  endfunction

  function [15:0] eq4;
    input [63:0] t;
    input [63:0] c;
    reg signed [35:0] acc;
    integer           k;
    begin
      acc = 36'sh0;
      for (k = 0; k < `VCP_EQ_TAPS; k = k + 1)
        acc = acc + $signed(t[16*k +: 16]) * $signed(c[16*k +: 16]);
      eq4 = sat16(acc >>> `VCP_COEF_SHIFT);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Companding

  function [7:0] mu_enc;
    input [15:0] x;
    reg [13:0] p;
    reg [13:0] m;
    reg [13:0] b;
    reg [13:0] s;
    reg [7:0]  mask;
    reg [3:0]  seg;
    integer    i;
    begin
      p    = x[15:2];
      mask = p[13] ? `VCP_MU_NEG : `VCP_MU_POS;
      m    = p[13] ? (~p + 14'h0001) : p;
      if (m > `VCP_MU_CLIP)
        m = `VCP_MU_CLIP;
      b   = m + `VCP_MU_BIAS;
      seg = 4'h0;
      for (i = 6; i < 14; i = i + 1)
        if (b[i])
          seg = i[3:0] - 4'h5;
      s = b >> (seg + 4'h1);
      if (seg[3])
        mu_enc = 8'h7F ^ mask;
      else
        mu_enc = {1'b0, seg[2:0], s[3:0]} ^ mask;
    end
  endfunction

  function [7:0] a_enc;
    input [15:0] x;
    reg [12:0] p;
    reg [12:0] m;
    reg [12:0] s;
    reg [7:0]  mask;
    reg [2:0]  seg;
    integer    i;
    begin
      p    = x[15:3];
      mask = p[12] ? `VCP_A_NEG : `VCP_A_POS;
      m    = p[12] ? ~p : p;
      seg  = 3'h0;
      for (i = 5; i < 12; i = i + 1)
        if (m[i])
          seg = i[2:0] - 3'h4;
      if (seg < 3'h2)
        s = m >> 1;
      else
        s = m >> seg;
      a_enc = {1'b0, seg, s[3:0]} ^ mask;
    end
  endfunction

  function [15:0] mu_dec;
    input [7:0] u;
    reg [7:0]  v;
    reg [15:0] t;
    begin
      v = ~u;
      t = ({9'h000, v[3:0], 3'h0} + `VCP_DEC_BIAS) << v[6:4];
      if (v[7])
        mu_dec = `VCP_DEC_BIAS - t;
      else
        mu_dec = t - `VCP_DEC_BIAS;
    end
  endfunction

  function [15:0] a_dec;
    input [7:0] u;
    reg [7:0]  a;
    reg [15:0] t;
    begin
      a = u ^ `VCP_A_NEG;
      t = {8'h00, a[3:0], 4'h0};
      if (a[6:4] == 3'h0)
        t = t + 16'h0008;
      else
        t = (t + `VCP_A_SEG1) << (a[6:4] - 3'h1);
      a_dec = a[7] ? t : (16'h0000 - t);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Transmit high-pass cascade

  reg  [2:0]         tx_state;
  reg  [15:0]        tx_in;
  wire signed [17:0] hp_x [0:`VCP_HPF_STAGES];

  assign hp_x[0] = {{2{tx_in[15]}}, tx_in};

  genvar g;
  generate
    for (g = 0; g < `VCP_HPF_STAGES; g = g + 1) begin : hpf
      reg  signed [17:0] prev_x;
      reg  signed [17:0] prev_y;
      wire signed [17:0] y;
      // First-order DC blocker, pole at 1 - 2^-shift
      assign y = hp_x[g] - prev_x + prev_y
                 - (prev_y >>> `VCP_HPF_SHIFT);
      assign hp_x[g+1] = y;
      always @(posedge clk) begin
        if (!nrst) begin
          prev_x <= 18'sh0;
          prev_y <= 18'sh0;
        end else if (tx_state == TX_HPF) begin
          prev_x <= hp_x[g];
          prev_y <= y;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Transmit sequencer

  reg  [63:0] tx_taps;
  reg  [15:0] tx_eq_out;
  reg  [15:0] tx_bytes;
  reg         tx_left;
  wire        fifo_in_ready;
  wire [15:0] tx_gained;

  assign tx_gained = tx_digital_mute ? 16'h0000
                     : gain(tx_eq_out, tx_gain_coeff);

  always @(posedge clk) begin
    if (!nrst) begin
      tx_state    <= TX_IDLE;
      tx_in       <= 16'h0000;
      tx_taps     <= 64'h0;
      tx_eq_out   <= 16'h0000;
      tx_bytes    <= 16'h0000;
      tx_left     <= 1'b0;
      adc_ready   <= 1'b1;
      dtmf_sample <= 16'h0000;
      dtmf_valid  <= 1'b0;
    end else begin
      dtmf_valid <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (adc_valid) begin
            tx_in     <= adc_sample;
            adc_ready <= 1'b0;
            tx_state  <= TX_HPF;
          end
        end
        TX_HPF: begin
          tx_taps  <= {tx_taps[47:0],
                       sat16({{18{hp_x[`VCP_HPF_STAGES][17]}},
                              hp_x[`VCP_HPF_STAGES]})};
          tx_state <= TX_EQ;
        end
        TX_EQ: begin
          tx_eq_out <= eq4(tx_taps, tx_eq_coeffs);
          tx_state  <= TX_GAIN;
        end
        TX_GAIN: begin
          if (dtmf_enable) begin
            dtmf_sample <= tx_gained;
            dtmf_valid  <= 1'b1;
          end
          if (compand_en) begin
            tx_bytes <= {law_alaw ? a_enc(tx_gained)
                                  : mu_enc(tx_gained), 8'h00};
            tx_left  <= 1'b0;
          end else begin
            tx_bytes <= tx_gained;
            tx_left  <= 1'b1;
          end
          tx_state <= TX_PUSH;
        end
        TX_PUSH: begin
          if (fifo_in_ready) begin
            if (tx_left) begin
              tx_bytes <= {tx_bytes[7:0], 8'h00};
              tx_left  <= 1'b0;
            end else begin
              adc_ready <= 1'b1;
              tx_state  <= TX_IDLE;
            end
          end
        end
        default: begin
          adc_ready <= 1'b1;
          tx_state  <= TX_IDLE;
        end
      endcase
    end
  end

  vcp_fifo #(
    .WIDTH (8),
    .DEPTH (`VCP_FIFO_DEPTH),
    .AW    (`VCP_FIFO_AW)
  ) u_tx_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_data   (tx_bytes[15:8]),
    .in_valid  (tx_state == TX_PUSH),
    .in_ready  (fifo_in_ready),
    .out_data  (tx_slot_data),
    .out_valid (tx_slot_valid),
    .out_ready (tx_slot_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // Receive sequencer

  reg  [1:0]  rx_state;
  reg  [7:0]  rx_hold;
  reg         rx_half;
  reg  [63:0] rx_taps;
  reg  [15:0] rx_eq_out;
  wire [15:0] rx_expanded;

  assign rx_expanded = law_alaw ? a_dec(rx_slot_data)
                                : mu_dec(rx_slot_data);

  always @(posedge clk) begin
    if (!nrst) begin
      rx_state   <= RX_IDLE;
      rx_hold    <= 8'h00;
      rx_half    <= 1'b0;
      rx_taps    <= 64'h0;
      rx_eq_out  <= 16'h0000;
      dac_sample <= 16'h0000;
      dac_valid  <= 1'b0;
    end else begin
      dac_valid <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (rx_slot_valid) begin
            if (!expansion_bypass_bit) begin
              rx_taps  <= {rx_taps[47:0], rx_expanded};
              rx_half  <= 1'b0;
              rx_state <= RX_EQ;
            end else if (!rx_half) begin
              rx_hold <= rx_slot_data;
              rx_half <= 1'b1;
            end else begin
              rx_taps  <= {rx_taps[47:0], rx_hold, rx_slot_data};
              rx_half  <= 1'b0;
              rx_state <= RX_EQ;
            end
          end
        end
        RX_EQ: begin
          rx_eq_out <= eq4(rx_taps, rx_eq_coeffs);
          rx_state  <= RX_GAIN;
        end
        RX_GAIN: begin
          dac_sample <= rx_digital_mute ? 16'h0000
                        : gain(rx_eq_out, rx_gain_coeff);
          dac_valid  <= 1'b1;
          rx_state   <= RX_IDLE;
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

endmodule // vcp_top
`default_nettype wire

// ### tb/vcp_top_properties.sv
`default_nettype none
module vcp_top_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Transmit side
  input wire logic        adc_valid,
  input wire logic        adc_ready,
  input wire logic        dtmf_enable,
  input wire logic [15:0] dtmf_sample,
  input wire logic        dtmf_valid,
  input wire logic        tx_digital_mute,
  input wire logic [7:0]  tx_slot_data,
  input wire logic        tx_slot_valid,
  input wire logic        tx_slot_ready,
  // Receive side
  input wire logic        rx_slot_valid,
  input wire logic [15:0] dac_sample,
  input wire logic        dac_valid,
  input wire logic        rx_digital_mute,
  input wire logic        expansion_bypass_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_take;
    adc_valid && adc_ready;
  endsequence
  sequence s_rx_byte;
    !rx_slot_valid [*2] ##1 (rx_slot_valid && !expansion_bypass_bit);
  endsequence
  chk_ready_hold: assert property (s_take |=> !adc_ready [*3])
    else $error("adc_ready back inside pipeline");
  // Tap pulse is registered in the gain state three edges after the take, and is sampled on the fourth
  chk_dtmf_latency: assert property (
    s_take ##0 dtmf_enable |-> ##4 dtmf_valid)
    else $error("dtmf_valid late");
  chk_dtmf_cause: assert property (
    dtmf_valid |-> $past(adc_valid && adc_ready, 4))
    else $error("dtmf_valid without sample");
  chk_tx_mute: assert property (dtmf_valid && tx_digital_mute
    && $past(tx_digital_mute) |-> dtmf_sample == 16'h0000)
    else $error("tx mute leaks");
  chk_rx_mute: assert property (dac_valid && rx_digital_mute
    && $past(rx_digital_mute) |-> dac_sample == 16'h0000)
    else $error("rx mute leaks");
  chk_dac_pulse: assert property (dac_valid |=> !dac_valid)
    else $error("dac_valid too long");
  chk_slot_hold: assert property (tx_slot_valid && !tx_slot_ready
    |=> tx_slot_valid && $stable(tx_slot_data))
    else $error("slot byte not held");
  chk_rx_latency: assert property (
    s_rx_byte |-> ##1 !dac_valid [*2] ##1 dac_valid)
    else $error("dac_valid timing");
endmodule // vcp_top_chk
bind vcp_top vcp_top_chk chk_u (.*);
`default_nettype wire

// ### tb/vcp_hwy_model.sv
`default_nettype none
module vcp_hwy_model (
  // Clock
  input  wire logic       clk,
  // Transmit slots
  input  wire logic [7:0] tx_slot_data,
  input  wire logic       tx_slot_valid,
  output var  logic       tx_slot_ready,
  input  wire logic       stall,
  // Receive slots
  output var  logic [7:0] rx_slot_data,
  output var  logic       rx_slot_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  initial begin
    tx_slot_ready = 1'b0;
    rx_slot_data  = 8'hA5;
    rx_slot_valid = 1'b0;
  end
  always @(posedge clk) begin
    tx_slot_ready <= !stall;
    if (tx_slot_valid && tx_slot_ready) got.push_back(tx_slot_data);
  end
  // Idle line shows the inverse of the last byte
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_slot_data  <= b;
    rx_slot_valid <= 1'b1;
    @(posedge clk);
    rx_slot_data  <= ~b;
    rx_slot_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule // vcp_hwy_model
`default_nettype wire

// ### tb/tb_vcp_top.sv
`default_nettype none
module tb_vcp_top;
  timeunit 1ns;
  timeprecision 1ps;
// Each side is evaluated once, so a queue pop is not repeated on mismatch
`define CHK(nm, e, g) begin chk_e = (e); chk_g = (g); comparisons++; \
  if (chk_g !== chk_e) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", nm, chk_e, chk_g); end end
  logic [63:0] chk_e, chk_g;
  logic [15:0] last_dtmf;
  logic        clk, nrst, adc_valid, dtmf_enable, stall, compand_en;
  logic        tx_digital_mute, rx_digital_mute, law_alaw;
  logic        expansion_bypass_bit;
  logic [15:0] adc_sample, tx_gain_coeff, rx_gain_coeff, last_dac;
  logic [63:0] tx_eq_coeffs, rx_eq_coeffs;
  wire  logic [15:0] dac_sample, dtmf_sample;
  wire  logic [7:0]  tx_slot_data, rx_slot_data;
  wire  logic        adc_ready, dac_valid, tx_slot_valid, tx_slot_ready;
  wire  logic        rx_slot_valid, dtmf_valid;
  int          n_mismatch, comparisons, ndtmf, n0;
  // Rows: mute, gain, received word, expected sample
  logic [63:0] rt [7] = '{64'h4000_1234_1234, 64'h2000_1234_091A,
    64'h7FFF_7000_7FFF, 64'h0000_1234_0000, 64'h7FFF_9000_8000,
    64'h1_4000_1234_0000, 64'h4000_1234_1234};
  // Rows: law, received byte, expected sample
  logic [31:0] et [5] = '{32'h0080_7D7C, 32'h0000_8284, 32'h00FF_0000,
    32'h01AA_7E00, 32'h012A_8200};
  vcp_top dut_u (.*);
  vcp_hwy_model hw_u (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dac_valid === 1'b1) last_dac = dac_sample;
    if (dtmf_valid === 1'b1) begin
      ndtmf++;
      last_dtmf = dtmf_sample;
    end
  end
  task automatic put(input logic [15:0] s);
    int i;
    i = 0;
    @(negedge clk);
    while (adc_ready !== 1'b1 && i < 300) begin
      @(negedge clk);
      i++;
    end
    if (i >= 300) n_mismatch++;
    @(posedge clk);
    adc_sample <= s;
    adc_valid  <= 1'b1;
    @(posedge clk);
    adc_valid  <= 1'b0;
  endtask
  task automatic rxw(input logic [15:0] w, input logic two);
    if (two) hw_u.send(w[15:8]);
    hw_u.send(w[7:0]);
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    {nrst, adc_valid, stall, tx_digital_mute, rx_digital_mute} = 5'h00;
    {dtmf_enable, compand_en, law_alaw, expansion_bypass_bit} = 4'hD;
    adc_sample = 16'h0000;
    tx_gain_coeff = 16'h4000;
    rx_gain_coeff = 16'h4000;
    tx_eq_coeffs = 64'h4000;
    rx_eq_coeffs = 64'h4000;
    {n_mismatch, comparisons, ndtmf} = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK("adc_ready", 1'b1, adc_ready)
    for (int k = 0; k < 7; k++) begin
      @(posedge clk);
      rx_digital_mute <= rt[k][48];
      rx_gain_coeff <= rt[k][47:32];
      rxw(rt[k][31:16], 1'b1);
      `CHK("dac_sample", rt[k][15:0], last_dac)
    end
    @(posedge clk);
    rx_eq_coeffs <= 64'h4000_0000;
    rxw(16'h5678, 1'b1);
    rxw(16'h0001, 1'b1);
    `CHK("eq_tap1", 16'h5678, last_dac)
    $display("test rx_bypass done");
    @(posedge clk);
    rx_eq_coeffs <= 64'h4000;
    expansion_bypass_bit <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      law_alaw <= et[k][24];
      rxw({8'h00, et[k][23:16]}, 1'b0);
      `CHK("expand", et[k][15:0], last_dac)
    end
    $display("test rx_expand done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      law_alaw <= k[0];
      put(16'h0000);
      repeat (8) @(posedge clk);
      `CHK("slot_byte", k ? 8'hD5 : 8'hFF, hw_u.got.pop_front())
    end
    // Filter history is still zero, so a step passes unchanged
    put(16'h1000);
    repeat (8) @(posedge clk);
    `CHK("slot_a", 8'h85, hw_u.got.pop_front())
    `CHK("dtmf_tap", 16'h1000, last_dtmf)
    n0 = ndtmf;
    @(posedge clk);
    tx_digital_mute <= 1'b1;
    put(16'h7000);
    repeat (8) @(posedge clk);
    `CHK("muted_byte", 8'hD5, hw_u.got.pop_front())
    `CHK("dtmf_on", n0 + 1, ndtmf)
    `CHK("dtmf_muted", 16'h0000, last_dtmf)
    dtmf_enable <= 1'b0;
    put(16'h0000);
    repeat (8) @(posedge clk);
    `CHK("dtmf_off", n0 + 1, ndtmf)
    `CHK("off_byte", 8'hD5, hw_u.got.pop_front())
    $display("test tx_compand done");
    {stall, compand_en} <= 2'h2;
    repeat (5) put(16'h1234);
    repeat (20) @(posedge clk);
    `CHK("ready_full", 1'b0, adc_ready)
    `CHK("held", 0, hw_u.got.size())
    stall <= 1'b0;
    repeat (30) @(posedge clk);
    `CHK("drained", 10, hw_u.got.size())
    `CHK("high_byte", 8'h00, hw_u.got.pop_front())
    $display("test tx_fifo done");
    close_out();
  end
endmodule // tb_vcp_top
`default_nettype wire
